/* hw/sefd_decoder.sv */
// submission entry field decoder with apb register access
`timescale 1ns/100ps
//
// Summary of operation
// - selector 01b/10b: bytes 39:24 are gather segment
// - data block first segment covers whole transfer
// - dwords ten..fifteen from bytes 43:40..63:60
// - invalid namespace aborts with namespace status
// - vendor command inactive namespace: implementer choice
// - vendor layout: bytes 43:40 data dword count
// - vendor layout: bytes 47:44 metadata dword count
// - vendor layout: pointers as standard, 15:08 reserved
// - page pointer entries have one fixed size
// - offset width from host page size setting
// - pointer 64 bits, bits 01:00 reserved
// - nonzero second pointer offset gives offset error
module sefd_decoder #(
   parameter int FIELD_COUNT = 6
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // interrupt
   output logic irq
);
   import sefd_pkg::*;

   sefd_store_if st ();   // entry store link

   // apb phase decode
   logic setup_w;            // setup cycle seen
   logic access_w;           // access completes this edge
   logic wr_w;               // write takes effect
   logic pready_q;           // registered ready
   logic [31:0] prdata_q;    // registered read data
   logic pslverr_q;          // registered error
   logic [31:0] rd_d;        // read mux output
   logic hit_d;              // address mapped

   // software registers
   logic vendor_q;           // vendor layout in use
   logic uses_ns_q;          // command uses namespace id
   logic second_ptr_q;       // second page pointer present
   logic [3:0] page_size_q;  // host_page_size_setting
   logic [31:0] ns_limit_q;  // highest valid namespace
   logic [31:0] ns_active_q; // highest active namespace
   logic [2:0] int_st_q;     // sticky event bits
   logic [2:0] int_msk_q;    // event enables
   logic [2:0] int_set_d;    // events this cycle
   logic irq_q;              // registered interrupt

   // decoder state
   sefd_state_t state_q;
   logic [4:0] cnt_q;        // read index issued
   logic [3:0] cap_idx_q;    // index of word arriving
   logic cap_vld_q;          // word arriving this cycle
   logic start_w;            // start request
   logic [1:0] sel_q;        // transfer_descriptor_selector
   logic [31:0] ns_ident_q;  // namespace_identifier
   logic [63:0] ptr1_q;      // first pointer or segment low half
   logic [63:0] ptr2_q;      // second pointer or segment high half
   logic [31:0] field_q [FIELD_COUNT];   // command specific dwords
   logic [7:0] code_q;       // completion code
   logic [7:0] code_d;
   logic single_q;           // one segment covers transfer
   logic chained_q;          // segment chaining used
   logic [31:0] ptr1_ofs_q;  // offset of first page pointer

   // offset mask of a page pointer for a page size setting
   function automatic logic [63:0] ofs_mask(input logic [3:0] psz);
      logic [6:0] sh;
      sh = SEFD_PAGE_SHIFT_BASE + {3'h0, psz};
      // bits 01:00 reserved, never part of the offset
      return ((64'h1 << sh) - 64'h1) & ~64'h3;
   endfunction

   // aligned word inside the sixteen dword entry window, nothing above it
   function automatic logic in_entry(input logic [7:0] a);
      return a >= SEFD_ENTRY_OFS && a < SEFD_ENTRY_OFS + 8'(4 * SEFD_ENTRY_DWORDS)
             && a[1:0] == 2'h0;
   endfunction

   // gather descriptor type from the top byte of the segment
   function automatic logic [3:0] sgl_type(input logic [63:0] hi);
      return hi[SEFD_SGL_TYPE_LSB + 32 +: 4];
   endfunction

   assign setup_w = psel && !penable;
   assign access_w = psel && penable && pready_q;
   assign wr_w = access_w && pwrite && !pslverr_q;
   assign start_w = wr_w && (paddr == SEFD_CTRL_OFS) && pwdata[SEFD_CTRL_START_BIT];

   // read mux and address decode
   always_comb begin
      rd_d = 32'h0000_0000;
      hit_d = 1'b1;
      if (in_entry(paddr)) begin
         rd_d = 32'h0000_0000;  // entry window is write only
      end else if (paddr >= SEFD_FIELD_OFS && paddr < SEFD_NSPACE_OFS && paddr[1:0] == 2'h0) begin
         rd_d = field_q[3'((paddr - SEFD_FIELD_OFS) >> 2)];
      end else begin
         unique case (paddr)
            SEFD_CTRL_OFS: begin
               rd_d[SEFD_CTRL_VENDOR_BIT] = vendor_q;
               rd_d[SEFD_CTRL_USES_NS_BIT] = uses_ns_q;
               rd_d[SEFD_CTRL_SECOND_PTR_BIT] = second_ptr_q;
            end
            SEFD_PAGE_OFS: rd_d[3:0] = page_size_q;
            SEFD_NSLIM_OFS: rd_d = ns_limit_q;
            SEFD_NSACT_OFS: rd_d = ns_active_q;
            SEFD_INTST_OFS: rd_d[2:0] = int_st_q;
            SEFD_INTMSK_OFS: rd_d[2:0] = int_msk_q;
            SEFD_RESULT_OFS: begin
               rd_d[1:0] = sel_q;
               rd_d[2] = (sel_q == SEFD_SEL_GATHER_A) || (sel_q == SEFD_SEL_GATHER_B);
               rd_d[3] = single_q;
               rd_d[4] = chained_q;
               rd_d[5] = vendor_q;
               rd_d[6] = !(state_q == SEFD_IDLE);
               rd_d[15:8] = code_q;
               rd_d[19:16] = sgl_type(ptr2_q);
            end
            SEFD_PTR1OFS_OFS: rd_d = ptr1_ofs_q;
            SEFD_NSPACE_OFS: rd_d = ns_ident_q;
            default: hit_d = 1'b0;   // unmapped address
         endcase
      end
   end

   // apb answer, ready one cycle after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setup_w;
         if (setup_w) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
            pslverr_q <= !hit_d;
         end else if (access_w) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
         end
      end
   end

   // control and configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vendor_q <= 1'b0;
         uses_ns_q <= 1'b0;
         second_ptr_q <= 1'b0;
         page_size_q <= SEFD_PAGE_RST;
         ns_limit_q <= SEFD_NSLIM_RST;
         ns_active_q <= SEFD_NSACT_RST;
         int_msk_q <= SEFD_INTMSK_RST;
      end else if (wr_w) begin
         unique case (paddr)
            SEFD_CTRL_OFS: begin
               vendor_q <= pwdata[SEFD_CTRL_VENDOR_BIT];
               uses_ns_q <= pwdata[SEFD_CTRL_USES_NS_BIT];
               second_ptr_q <= pwdata[SEFD_CTRL_SECOND_PTR_BIT];
            end
            SEFD_PAGE_OFS: page_size_q <= pwdata[3:0];
            SEFD_NSLIM_OFS: ns_limit_q <= pwdata;
            SEFD_NSACT_OFS: ns_active_q <= pwdata;
            SEFD_INTMSK_OFS: int_msk_q <= pwdata[2:0];
            default: ;   // other offsets hold no settings
         endcase
      end
   end

   // entry window writes go to the store, dropped without error while decoding
   always_comb begin
      st.wr_en = wr_w && in_entry(paddr) && state_q == SEFD_IDLE;
      st.wr_idx = 4'((paddr - SEFD_ENTRY_OFS) >> 2);
      st.wr_data = pwdata;
      st.rd_en = state_q == SEFD_FETCH && cnt_q < 5'(SEFD_ENTRY_DWORDS);
      st.rd_idx = cnt_q[3:0];
   end

   sefd_entry_store #(
      .DEPTH(SEFD_ENTRY_DWORDS)
   ) u_store (
      .pclk(pclk),
      .presetn(presetn),
      .st(st)
   );

   // decode state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SEFD_IDLE;
         cnt_q <= 5'h00;
         cap_vld_q <= 1'b0;
         cap_idx_q <= 4'h0;
      end else begin
         cap_vld_q <= st.rd_en;
         cap_idx_q <= st.rd_idx;
         unique case (state_q)
            SEFD_IDLE: begin
               cnt_q <= 5'h00;
               if (start_w) begin
                  state_q <= SEFD_FETCH;
               end
            end
            SEFD_FETCH: begin
               if (st.rd_en) begin
                  cnt_q <= cnt_q + 5'h01;
               end else if (!cap_vld_q) begin
                  state_q <= SEFD_CHECK;   // last word captured
               end
            end
            SEFD_CHECK: state_q <= SEFD_DONE;
            SEFD_DONE: state_q <= SEFD_IDLE;
            default: state_q <= SEFD_IDLE;
         endcase
      end
   end

   // field capture as words arrive from the store
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= 2'h0;
         ns_ident_q <= 32'h0000_0000;
         ptr1_q <= 64'h0000_0000_0000_0000;
         ptr2_q <= 64'h0000_0000_0000_0000;
         for (int i = 0; i < FIELD_COUNT; i++) begin
            field_q[i] <= 32'h0000_0000;
         end
      end else if (cap_vld_q) begin
         // dwords 2, 3 and pointer bytes 23:16 are not kept
         if (cap_idx_q == SEFD_DW_HEAD) begin
            sel_q <= st.rd_data[SEFD_SEL_LSB +: 2];
         end
         if (cap_idx_q == SEFD_DW_NSPACE) begin
            ns_ident_q <= st.rd_data;
         end
         // bytes 39:24 decoded alike in both layouts
         if (cap_idx_q == SEFD_DW_PTR1_LO) begin
            ptr1_q[31:0] <= st.rd_data;
         end
         if (cap_idx_q == SEFD_DW_PTR1_HI) begin
            ptr1_q[63:32] <= st.rd_data;
         end
         if (cap_idx_q == SEFD_DW_PTR2_LO) begin
            ptr2_q[31:0] <= st.rd_data;
         end
         if (cap_idx_q == SEFD_DW_PTR2_HI) begin
            ptr2_q[63:32] <= st.rd_data;
         end
         // dwords ten onward; first two are counts in vendor layout
         if (cap_idx_q >= SEFD_DW_TEN) begin
            field_q[3'(cap_idx_q - SEFD_DW_TEN)] <= st.rd_data;
         end
      end
   end

   // checks producing the completion code
   always_comb begin
      code_d = SEFD_SC_OK;
      if (uses_ns_q && ns_ident_q != SEFD_NS_ALL
          && (ns_ident_q == SEFD_NS_UNUSED || ns_ident_q > ns_limit_q)) begin
         code_d = SEFD_SC_BAD_NS;
      end else if (uses_ns_q && ns_ident_q != SEFD_NS_ALL && ns_ident_q > ns_active_q) begin
         // inactive id: vendor commands proceed, others refused
         code_d = vendor_q ? SEFD_SC_OK : SEFD_SC_BAD_FIELD;
      end else if (!(sel_q == SEFD_SEL_PAGE || sel_q == SEFD_SEL_GATHER_A
                     || sel_q == SEFD_SEL_GATHER_B)) begin
         code_d = SEFD_SC_BAD_FIELD;   // reserved selector
      end else if (sel_q == SEFD_SEL_PAGE && second_ptr_q
                   && (ptr2_q & ofs_mask(page_size_q)) != 64'h0) begin
         code_d = SEFD_SC_BAD_OFFSET;
      end
   end

   // results latched at the check step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_q <= SEFD_SC_OK;
         single_q <= 1'b0;
         chained_q <= 1'b0;
         ptr1_ofs_q <= 32'h0000_0000;
      end else if (state_q == SEFD_CHECK) begin
         code_q <= code_d;
         // gather selectors use bytes 39:24 as first segment
         if (sel_q == SEFD_SEL_GATHER_A || sel_q == SEFD_SEL_GATHER_B) begin
            single_q <= sgl_type(ptr2_q) == SEFD_SGL_DATA
                        || sgl_type(ptr2_q) == SEFD_SGL_KEYED;
            chained_q <= sgl_type(ptr2_q) == SEFD_SGL_SEGMENT
                         || sgl_type(ptr2_q) == SEFD_SGL_LAST;
            ptr1_ofs_q <= 32'h0000_0000;
         end else begin
            single_q <= 1'b0;
            chained_q <= 1'b0;
            ptr1_ofs_q <= 32'(ptr1_q & ofs_mask(page_size_q));
         end
      end
   end

   // events raised at the end of a decode
   always_comb begin
      int_set_d = 3'h0;
      if (state_q == SEFD_DONE) begin
         int_set_d[SEFD_INT_DONE_BIT] = 1'b1;
         int_set_d[SEFD_INT_ABORT_BIT] = code_q == SEFD_SC_BAD_NS || code_q == SEFD_SC_BAD_FIELD;
         int_set_d[SEFD_INT_OFFSET_BIT] = code_q == SEFD_SC_BAD_OFFSET;
      end
   end

   // sticky status, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_st_q <= 3'h0;
      end else if (wr_w && paddr == SEFD_INTST_OFS) begin
         int_st_q <= (int_st_q & ~pwdata[2:0]) | int_set_d;
      end else begin
         int_st_q <= int_st_q | int_set_d;
      end
   end

   // level interrupt from masked status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(int_st_q & int_msk_q);
      end
   end

   assign pready = pready_q;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;

endmodule // sefd_decoder

/* hw/sefd_entry_store.sv */
// sixteen dword store holding one submission entry
`timescale 1ns/100ps
module sefd_entry_store #(
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // access port
   sefd_store_if.mem st
);
   import sefd_pkg::*;

   logic [31:0] mem_q [DEPTH];   // entry words
   logic [31:0] rd_q;            // registered read data

   // write port, no reset on the array
   always_ff @(posedge pclk) begin
      if (st.wr_en) begin
         mem_q[st.wr_idx] <= st.wr_data;
      end
   end

   // read port, one cycle latency
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_q <= 32'h0000_0000;
      end else if (st.rd_en) begin
         rd_q <= mem_q[st.rd_idx];
      end
   end

   assign st.rd_data = rd_q;
endmodule // sefd_entry_store

/* pkg/sefd_pkg.sv */
// constants, layouts and types for the submission entry field decoder
package sefd_pkg;

   // apb register byte offsets
   localparam logic [7:0] SEFD_CTRL_OFS = 8'h00;
   localparam logic [7:0] SEFD_PAGE_OFS = 8'h04;
   localparam logic [7:0] SEFD_NSLIM_OFS = 8'h08;
   localparam logic [7:0] SEFD_NSACT_OFS = 8'h0C;
   localparam logic [7:0] SEFD_INTST_OFS = 8'h10;
   localparam logic [7:0] SEFD_INTMSK_OFS = 8'h14;
   localparam logic [7:0] SEFD_RESULT_OFS = 8'h18;
   localparam logic [7:0] SEFD_PTR1OFS_OFS = 8'h1C;
   localparam logic [7:0] SEFD_FIELD_OFS = 8'h20;
   localparam logic [7:0] SEFD_NSPACE_OFS = 8'h38;
   localparam logic [7:0] SEFD_ENTRY_OFS = 8'h40;

   // control register bit positions
   localparam int SEFD_CTRL_START_BIT = 0;
   localparam int SEFD_CTRL_VENDOR_BIT = 1;
   localparam int SEFD_CTRL_USES_NS_BIT = 2;
   localparam int SEFD_CTRL_SECOND_PTR_BIT = 3;

   // interrupt status bit positions
   localparam int SEFD_INT_DONE_BIT = 0;
   localparam int SEFD_INT_ABORT_BIT = 1;
   localparam int SEFD_INT_OFFSET_BIT = 2;

   // reset values
   localparam logic [3:0] SEFD_PAGE_RST = 4'h0;
   localparam logic [31:0] SEFD_NSLIM_RST = 32'h0000_0001;
   localparam logic [31:0] SEFD_NSACT_RST = 32'h0000_0001;
   localparam logic [2:0] SEFD_INTMSK_RST = 3'h0;

   // entry geometry: 16 dwords of 4 bytes
   localparam int SEFD_ENTRY_DWORDS = 16;
   localparam logic [3:0] SEFD_DW_HEAD = 4'h0;
   localparam logic [3:0] SEFD_DW_NSPACE = 4'h1;
   localparam logic [3:0] SEFD_DW_PTR1_LO = 4'h6;
   localparam logic [3:0] SEFD_DW_PTR1_HI = 4'h7;
   localparam logic [3:0] SEFD_DW_PTR2_LO = 4'h8;
   localparam logic [3:0] SEFD_DW_PTR2_HI = 4'h9;
   localparam logic [3:0] SEFD_DW_TEN = 4'hA;
   localparam int SEFD_SEL_LSB = 14;
   localparam int SEFD_SGL_TYPE_LSB = 28;

   // selector encodings
   localparam logic [1:0] SEFD_SEL_PAGE = 2'h0;
   localparam logic [1:0] SEFD_SEL_GATHER_A = 2'h1;
   localparam logic [1:0] SEFD_SEL_GATHER_B = 2'h2;

   // gather descriptor type codes
   localparam logic [3:0] SEFD_SGL_DATA = 4'h0;
   localparam logic [3:0] SEFD_SGL_SEGMENT = 4'h2;
   localparam logic [3:0] SEFD_SGL_LAST = 4'h3;
   localparam logic [3:0] SEFD_SGL_KEYED = 4'h4;

   // namespace constants
   localparam logic [31:0] SEFD_NS_UNUSED = 32'h0000_0000;
   localparam logic [31:0] SEFD_NS_ALL = 32'hFFFF_FFFF;

   // page sizing: smallest page is 2^12 bytes
   localparam logic [6:0] SEFD_PAGE_SHIFT_BASE = 7'h0C;

   // completion codes reported in the result register
   localparam logic [7:0] SEFD_SC_OK = 8'h00;
   localparam logic [7:0] SEFD_SC_BAD_NS = 8'h01;
   localparam logic [7:0] SEFD_SC_BAD_FIELD = 8'h02;
   localparam logic [7:0] SEFD_SC_BAD_OFFSET = 8'h03;

   // decoder states, one-hot
   typedef enum logic [3:0] {
      SEFD_IDLE = 4'b0001,
      SEFD_FETCH = 4'b0010,
      SEFD_CHECK = 4'b0100,
      SEFD_DONE = 4'b1000
   } sefd_state_t;

endpackage

/* pkg/sefd_store_if.sv */
// carrier between the decoder and its entry store
`timescale 1ns/100ps
interface sefd_store_if;
   logic wr_en;
   logic [3:0] wr_idx;
   logic [31:0] wr_data;
   logic rd_en;
   logic [3:0] rd_idx;
   logic [31:0] rd_data;
   modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_en, output rd_idx,
                 input rd_data);
   modport mem (input wr_en, input wr_idx, input wr_data, input rd_en, input rd_idx,
                output rd_data);
endinterface

/* sim/sefd_decoder_sva.sv */
// port-level assertions for the decoder register bus and interrupt
`timescale 1ns/100ps
module sefd_decoder_sva (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // interrupt
   input wire logic irq
);
   import sefd_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // decoded address map: aligned words below 0x80, hole at 0x3C
   function automatic logic mapped(logic [7:0] a);
      return (a[1:0] == 2'h0) && (a != 8'h3C) && (a < 8'h80);
   endfunction
   // setup phase of a transfer
   sequence setup_s;
      psel && !penable;
   endsequence
   // completing access phase
   sequence access_s;
      psel && penable && pready;
   endsequence
   a_ready_after_setup: assert property (setup_s |=> access_s) // bus
      else $error("ready missing after setup");
   a_ready_one_cycle: assert property (pready |=> !pready) // bus
      else $error("ready longer than one cycle");
   a_ready_in_access: assert property (pready |-> psel && penable) // bus
      else $error("ready outside access");
   a_err_unmapped: assert property (access_s ##0 !mapped(paddr) |-> pslverr) // bus
      else $error("unmapped access not refused");
   a_err_mapped_ok: assert property (access_s ##0 mapped(paddr) |-> !pslverr) // bus
      else $error("mapped access refused");
   a_err_data_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_irq_mask_off: assert property (access_s ##0 (pwrite && paddr == SEFD_INTMSK_OFS
      && pwdata[2:0] == 3'h0) |=> ##1 !irq) // irq
      else $error("irq high with mask cleared");
   a_irq_quiet_start: assert property ($rose(presetn) |-> !irq && !pready) // reset
      else $error("outputs active after reset");
endmodule // sefd_decoder_sva

/* sim/sefd_decoder_test.sv */
// self-checking bench for the submission entry field decoder
`timescale 1ns/100ps
module sefd_decoder_test;
   import sefd_pkg::*;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   logic irq;
   logic [31:0] ent [16]; // entry image built by the host
   logic [31:0] rv; // last read value
   logic ev; // last error flag
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   // host driver model
   sefd_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
   // block under test
   sefd_decoder #(.FIELD_COUNT(6)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .irq(irq));
   // 20 mhz clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // watchdog against hangs
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         end_of_test;
      end
   end
   // verdict and end of run
   task automatic end_of_test;
      if (failures == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // compare seen against expected
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // register write and read helpers
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rv, ev);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h0, rv, ev);
      chk(rv, exp);
   endtask
   // fresh entry: reserved dwords carry junk that must not matter
   task automatic fresh(input logic [1:0] sel);
      for (int k = 0; k < 16; k++) ent[k] = 32'h0;
      ent[2] = 32'hDEAD_BEEF;
      ent[3] = 32'hA5A5_5A5A;
      ent[0][15:14] = sel;
   endtask
   // load entry, start decode, wait for busy to drop; rv ends as result
   task automatic run(input logic [3:0] flags);
      for (int k = 0; k < 16; k++) wr(SEFD_ENTRY_OFS + 8'(4 * k), ent[k]);
      wr(SEFD_CTRL_OFS, {28'h0, flags} | 32'h1);
      do host.xfer(1'b0, SEFD_RESULT_OFS, 32'h0, rv, ev); while (rv[6] !== 1'b0);
   endtask
   // reset values and the refused address 0x3C
   task automatic t_reset;
      rchk(SEFD_PAGE_OFS, 32'h0);
      rchk(SEFD_NSLIM_OFS, SEFD_NSLIM_RST);
      rchk(SEFD_NSACT_OFS, SEFD_NSACT_RST);
      rchk(SEFD_INTMSK_OFS, 32'h0);
      rchk(SEFD_INTST_OFS, 32'h0);
      rchk(8'h3C, 32'h0);
      chk(32'(ev), 32'h1);
   endtask
   // both gather selectors with every descriptor type, then reserved selector
   task automatic t_gather;
      logic [3:0] ty [4] = '{SEFD_SGL_DATA, SEFD_SGL_SEGMENT, SEFD_SGL_LAST, SEFD_SGL_KEYED};
      logic sg;
      for (int s = 1; s < 3; s++) begin
         for (int i = 0; i < 4; i++) begin
            fresh(2'(s));
            ent[9][31:28] = ty[i];
            sg = (ty[i] == SEFD_SGL_DATA) || (ty[i] == SEFD_SGL_KEYED);
            if (!sg) ent[8] = 32'h0000_1000;
            run(4'h0);
            chk(rv & 32'h000F_FF7F,
                {12'h0, ty[i], SEFD_SC_OK, 3'h0, !sg, sg, 1'b1, 2'(s)});
         end
      end
      fresh(2'h3);
      run(4'h0);
      chk(32'(rv[15:8]), 32'(SEFD_SC_BAD_FIELD));
   endtask
   // standard dwords ten..fifteen, then vendor counts and pointer
   task automatic t_fields;
      fresh(SEFD_SEL_PAGE);
      for (int k = 10; k < 16; k++) ent[k] = 32'(32'h1111_1111 * k);
      run(4'h0);
      chk(32'(rv[2]), 32'h0);
      for (int k = 10; k < 16; k++) begin
         rchk(SEFD_FIELD_OFS + 8'(4 * (k - 10)), 32'(32'h1111_1111 * k));
      end
      ent[10] = 32'h0000_0040;
      ent[11] = 32'h0000_0008;
      ent[6] = 32'h0000_0123;
      run(4'h2);
      chk(32'(rv[5]), 32'h1);
      rchk(SEFD_FIELD_OFS, 32'h40);
      rchk(SEFD_FIELD_OFS + 8'h04, 32'h8);
      rchk(SEFD_PTR1OFS_OFS, 32'h120);
   endtask
   // namespace identifiers: out of range, all, unused, valid, inactive
   task automatic t_ns;
      logic [31:0] ids [4] = '{32'h5, SEFD_NS_ALL, SEFD_NS_UNUSED, 32'h1};
      logic [7:0] cd [4] = '{SEFD_SC_BAD_NS, SEFD_SC_OK, SEFD_SC_BAD_NS, SEFD_SC_OK};
      for (int i = 0; i < 4; i++) begin
         wr(SEFD_INTST_OFS, 32'h7);
         fresh(SEFD_SEL_PAGE);
         ent[1] = ids[i];
         run(4'h4);
         chk(32'(rv[15:8]), 32'(cd[i]));
         rchk(SEFD_INTST_OFS, (cd[i] == SEFD_SC_OK) ? 32'h1 : 32'h3);
      end
      rchk(SEFD_NSPACE_OFS, 32'h1);
      wr(SEFD_NSLIM_OFS, 32'h4);
      wr(SEFD_NSACT_OFS, 32'h2);
      ent[1] = 32'h3;
      run(4'h4);
      chk(32'(rv[15:8]), 32'(SEFD_SC_BAD_FIELD));
      run(4'h6);
      chk(32'(rv[15:8]), 32'(SEFD_SC_OK));
   endtask
   // second pointer offset against page size, reserved low bits
   task automatic t_offset;
      logic [31:0] p2 [4] = '{32'h0000_0800, 32'h0000_1000, 32'h0000_1000, 32'h0000_2003};
      logic [7:0] cd [4] = '{SEFD_SC_BAD_OFFSET, SEFD_SC_OK, SEFD_SC_BAD_OFFSET, SEFD_SC_OK};
      for (int i = 0; i < 4; i++) begin
         wr(SEFD_PAGE_OFS, 32'(i / 2));
         fresh(SEFD_SEL_PAGE);
         ent[6] = 32'h0000_1ABF;
         ent[8] = p2[i];
         run(4'h8);
         chk(32'(rv[15:8]), 32'(cd[i]));
         rchk(SEFD_PTR1OFS_OFS, (i / 2) ? 32'h1ABC : 32'h0ABC);
      end
      wr(SEFD_PAGE_OFS, 32'h0);
   endtask
   // interrupt raised, masked out and cleared
   task automatic t_irq;
      wr(SEFD_INTST_OFS, 32'h7);
      wr(SEFD_INTMSK_OFS, 32'h1);
      fresh(SEFD_SEL_PAGE);
      run(4'h0);
      rchk(SEFD_INTST_OFS, 32'h1);
      chk(32'(irq), 32'h1);
      wr(SEFD_INTMSK_OFS, 32'h2);
      rchk(SEFD_INTMSK_OFS, 32'h2);
      chk(32'(irq), 32'h0);
      wr(SEFD_INTMSK_OFS, 32'h1);
      wr(SEFD_INTST_OFS, 32'h1);
      rchk(SEFD_INTST_OFS, 32'h0);
      chk(32'(irq), 32'h0);
      wr(SEFD_INTMSK_OFS, 32'h0);
   endtask
   // main sequence
   initial begin
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_gather;
      t_fields;
      t_ns;
      t_offset;
      t_irq;
      end_of_test;
   end
endmodule // sefd_decoder_test

bind sefd_decoder sefd_decoder_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .irq(irq));

/* sim/sefd_host_model.sv */
// host-side apb master model issuing register transfers to the decoder
`timescale 1ns/100ps
module sefd_host_model (
   // clock
   input wire logic pclk,
   // apb master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr
);
   // bus idle from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // one transfer: setup, then access held until ready is seen at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released address and data lines show the inverse, never a stale copy; pwrite keeps its value
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule // sefd_host_model
